// ===== pmc_defines.svh
// constants of the power mode controller: register offsets, field positions,
// reset values and timing counts
// assumes inclusion by bare name from the package and the controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// register byte offsets on the apb bus
`define PMC_CTRL_OFS 12'h000
`define PMC_STAT_OFS 12'h004
`define PMC_ADDR_W 12

// control register fields
`define PMC_CTRL_SLOW_BIT 0
`define PMC_CTRL_DIV_LSB 1
`define PMC_CTRL_DIV_MSB 2
`define PMC_CTRL_OIE_BIT 3
`define PMC_CTRL_STAB_BIT 4
`define PMC_CTRL_RST 5'h00

// status register fields
`define PMC_STAT_MODE_LSB 0
`define PMC_STAT_MODE_MSB 2
`define PMC_STAT_OSC_BIT 3
`define PMC_STAT_SLOW_BIT 4

// interrupt mask level forced on low power entry
`define PMC_MASK_ALL_EN 2'b10

// oscillator stabilisation delay in master clock cycles
`define PMC_STAB_SHORT 13'd256
`define PMC_STAB_LONG 13'd4096

`endif

// ===== pmc_pkg.sv
// types of the power mode controller
// assumes pmc_defines.svh is on the include path
`default_nettype none
`include "pmc_defines.svh"

package pmc_pkg;
   // controller states; slow-wait is wait with slow mode enabled
   typedef enum logic [2:0] {
      PMC_RUN,
      PMC_WAIT,
      PMC_AHALT,
      PMC_HALT,
      PMC_STAB
   } pmc_state_t;

   // mode code shown in the status register
   typedef logic [2:0] pmc_mode_t;

   // what woke the device, kept across the stabilisation delay
   typedef enum logic [1:0] {
      PMC_CAUSE_NONE,
      PMC_CAUSE_IRQ,
      PMC_CAUSE_RST
   } pmc_cause_t;
endpackage

`default_nettype wire

// ===== pmc_ctrl.sv
// power mode controller: run, slow, wait, slow-wait, active-halt and halt
// assumes CLK_I is the master clock; core and peripheral clocks are gated
// from it by the enable outputs; interrupt and reset requests are async
//
// Operation
// [R01] reset enters run at master clock
// [R02] slow enable and two-bit divider select
// [R03] slow clock is master over 2,4,8,16
// [R04] wait during slow gives slow-wait
// [R05] wait stops core, peripherals keep running
// [R06] wait entry forces mask to 10
// [R07] wait ends on interrupt or reset
// [R08] halt goes active-halt when oscillator irq enabled
// [R09] active-halt exits fast on interrupt
// [R10] active-halt entry forces mask, pending wakes
// [R11] active-halt keeps only oscillator and time-base
// [R12] active-halt with enable gives no watchdog reset
// [R13] active-halt reset exit waits stabilisation
// [R14] halt exit restarts oscillator, then delay
// [R15] halt entry forces mask, pending wakes
// [R16] halt switches oscillator and all clocks off
// [R17] halt with watchdog may reset per option
// [R18] interrupt wake asks core to push flags
// [R19] gating and divider change on boundaries
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defines.svh"

module pmc_ctrl (
   input wire logic CLK_I,
   input wire logic RST_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [`PMC_ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // core instruction strobes
   input wire logic WAIT_INSTR_I,
   input wire logic HALT_INSTR_I,
   // asynchronous requests
   input wire logic IRQ_PENDING_I,
   input wire logic HALT_WAKE_IRQ_I,
   input wire logic TIMEBASE_IRQ_I,
   input wire logic RESET_REQ_I,
   // watchdog
   input wire logic WDG_ACTIVE_I,
   input wire logic WDG_IN_HALT_OPT_I,
   // clock gating
   output logic OSC_ENABLE_O,
   output logic CORE_CLK_EN_O,
   output logic PERIPH_CLK_EN_O,
   output logic TIMEBASE_CLK_EN_O,
   // core hand-off
   output logic MASK_FORCE_O,
   output logic [1:0] MASK_VALUE_O,
   output logic IRQ_SERVICE_O,
   output logic RESET_VECTOR_O,
   output logic WDG_RESET_O,
   output pmc_pkg::pmc_mode_t MODE_O
);
   import pmc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // divider limit: divide by 2 << sel in slow mode, else every cycle
   function automatic logic [3:0] div_limit(input logic slow, input logic [1:0] sel);
      logic [4:0] d;
      d = 5'h02 << sel;
      div_limit = slow ? (d[3:0] - 4'h1) : 4'h0;
      if (slow && sel == 2'b11) begin
         div_limit = 4'hf;
      end
   endfunction

   // status mode code for a state
   function automatic pmc_mode_t mode_code(input pmc_state_t s);
      mode_code = pmc_mode_t'(s);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // synchroniser for the asynchronous requests

   logic [3:0] req_s1_r;
   logic [3:0] req_s2_r;
   logic irq_s;
   logic hwake_s;
   logic tbase_s;
   logic rstreq_s;

   // two flops; only the second stage is read by logic
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         req_s1_r <= 4'h0;
         req_s2_r <= 4'h0;
      end else begin
         req_s1_r <= {RESET_REQ_I, TIMEBASE_IRQ_I, HALT_WAKE_IRQ_I, IRQ_PENDING_I};
         req_s2_r <= req_s1_r;
      end
   end

   assign irq_s = req_s2_r[0];
   assign hwake_s = req_s2_r[1];
   assign tbase_s = req_s2_r[2];
   assign rstreq_s = req_s2_r[3];

   ////////////////////////////////////////////////////////////////////////
   // apb register file

   logic [4:0] ctrl_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic setup;
   logic access_done;
   logic addr_ok;
   logic slow_en;
   logic [1:0] div_sel;
   logic osc_ie;
   logic stab_long;
   pmc_state_t state_r;
   pmc_state_t state_nxt;
   logic osc_en_r;

   assign setup = PSEL_I && !PENABLE_I;
   assign access_done = PSEL_I && PENABLE_I && pready_r;
   assign addr_ok = (PADDR_I == `PMC_CTRL_OFS) || (PADDR_I == `PMC_STAT_OFS);
   assign slow_en = ctrl_r[`PMC_CTRL_SLOW_BIT]; // see [R02]
   assign div_sel = ctrl_r[`PMC_CTRL_DIV_MSB:`PMC_CTRL_DIV_LSB]; // see [R02]
   assign osc_ie = ctrl_r[`PMC_CTRL_OIE_BIT];
   assign stab_long = ctrl_r[`PMC_CTRL_STAB_BIT];

   // no wait states: pready rises in the access phase, answer is registered
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !addr_ok;
         if (setup && !PWRITE_I) begin
            prdata_r <= 32'h0000_0000;
            if (PADDR_I == `PMC_CTRL_OFS) begin
               prdata_r <= {27'h0000000, ctrl_r};
            end else if (PADDR_I == `PMC_STAT_OFS) begin
               prdata_r <= {27'h0000000, slow_en, osc_en_r, mode_code(state_r)};
            end
         end
      end
   end

   // control register, written only at the completing edge
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_r <= `PMC_CTRL_RST;
      end else if (access_done && PWRITE_I && PADDR_I == `PMC_CTRL_OFS) begin
         ctrl_r <= PWDATA_I[4:0];
      end
   end

   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign PRDATA_O = prdata_r;

   ////////////////////////////////////////////////////////////////////////
   // mode state machine

   logic [12:0] stab_cnt_r;
   pmc_cause_t cause_r;
   logic enter_low;

   // reset value is run; run exits only on the core's instructions
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PMC_RUN: begin
            if (WAIT_INSTR_I) begin
               state_nxt = PMC_WAIT; // see [R04] [R05]
            end else if (HALT_INSTR_I) begin
               state_nxt = osc_ie ? PMC_AHALT : PMC_HALT; // see [R08]
            end
         end
         PMC_WAIT: begin
            if (irq_s || rstreq_s) begin
               state_nxt = PMC_RUN; // see [R07]
            end
         end
         PMC_AHALT: begin
            if (rstreq_s) begin
               state_nxt = PMC_STAB; // see [R13]
            end else if (tbase_s || hwake_s) begin
               state_nxt = PMC_RUN; // see [R09] [R10]
            end
         end
         PMC_HALT: begin
            if (rstreq_s || hwake_s) begin
               state_nxt = PMC_STAB; // see [R14] [R15]
            end
         end
         PMC_STAB: begin
            if (stab_cnt_r == 13'd0) begin
               state_nxt = PMC_RUN;
            end
         end
         default: state_nxt = PMC_RUN;
      endcase
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r <= PMC_RUN; // see [R01]
      end else begin
         state_r <= state_nxt;
      end
   end

   assign enter_low = (state_r == PMC_RUN) && (WAIT_INSTR_I || HALT_INSTR_I);

   // stabilisation counter, loaded on entry to the delay
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         stab_cnt_r <= 13'd0;
      end else if (state_r != PMC_STAB && state_nxt == PMC_STAB) begin
         stab_cnt_r <= (stab_long ? `PMC_STAB_LONG : `PMC_STAB_SHORT) - 13'd1; // see [R14]
      end else if (state_r == PMC_STAB && stab_cnt_r != 13'd0) begin
         stab_cnt_r <= stab_cnt_r - 13'd1;
      end
   end

   // wake cause survives the delay so the right vector follows it
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cause_r <= PMC_CAUSE_NONE;
      end else if (state_r != PMC_STAB && state_nxt == PMC_STAB) begin
         cause_r <= rstreq_s ? PMC_CAUSE_RST : PMC_CAUSE_IRQ;
      end else if (state_nxt == PMC_RUN) begin
         cause_r <= PMC_CAUSE_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // core hand-off strobes

   logic mask_force_r;
   logic irq_svc_r;
   logic rst_vec_r;
   logic wdg_rst_r;
   logic [1:0] mask_val_r;
   logic wake_rst;
   logic wake_irq;

   assign wake_rst = (state_r != PMC_RUN) && (state_nxt == PMC_RUN) &&
                     ((state_r == PMC_STAB) ? (cause_r == PMC_CAUSE_RST) : rstreq_s);
   assign wake_irq = (state_r != PMC_RUN) && (state_nxt == PMC_RUN) && !wake_rst;

   // mask forced on every low power entry; reset has priority over irq
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mask_force_r <= 1'b0;
         irq_svc_r <= 1'b0;
         rst_vec_r <= 1'b0;
         mask_val_r <= `PMC_MASK_ALL_EN;
      end else begin
         mask_force_r <= enter_low; // see [R06] [R10] [R15]
         mask_val_r <= `PMC_MASK_ALL_EN; // see [R06] [R10] [R15]
         irq_svc_r <= wake_irq; // see [R18]
         rst_vec_r <= wake_rst; // see [R07] [R13]
      end
   end

   // watchdog reset on plain halt only; option low allows the reset
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wdg_rst_r <= 1'b0;
      end else begin
         wdg_rst_r <= (state_r == PMC_RUN) && !WAIT_INSTR_I && HALT_INSTR_I && !osc_ie &&
                      WDG_ACTIVE_I && !WDG_IN_HALT_OPT_I; // see [R12] [R17]
      end
   end

   assign MASK_FORCE_O = mask_force_r;
   assign MASK_VALUE_O = mask_val_r;
   assign IRQ_SERVICE_O = irq_svc_r;
   assign RESET_VECTOR_O = rst_vec_r;
   assign WDG_RESET_O = wdg_rst_r;

   ////////////////////////////////////////////////////////////////////////
   // clock divider and gating

   logic [3:0] div_cnt_r;
   logic [3:0] lim_r;
   logic tick;
   logic core_en_r;
   logic per_en_r;
   logic tb_en_r;
   pmc_mode_t mode_r;

   assign tick = (div_cnt_r == lim_r);

   // a new divider only takes over at a period end, avoiding short pulses
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         div_cnt_r <= 4'h0;
         lim_r <= 4'h0;
      end else if (tick) begin
         div_cnt_r <= 4'h0;
         lim_r <= div_limit(slow_en, div_sel); // see [R03] [R19]
      end else begin
         div_cnt_r <= div_cnt_r + 4'h1;
      end
   end

   // core and peripheral enables change on ticks; all follow the next state, so no pulse leaks in
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         core_en_r <= 1'b0;
         per_en_r <= 1'b0;
         tb_en_r <= 1'b0;
      end else begin
         core_en_r <= tick && (state_nxt == PMC_RUN); // see [R05] [R19]
         per_en_r <= tick && (state_nxt == PMC_RUN || state_nxt == PMC_WAIT); // see [R04] [R11]
         tb_en_r <= (state_nxt != PMC_HALT) && (state_nxt != PMC_STAB); // see [R11]
      end
   end

   // oscillator off only in halt, restarted the cycle halt is left
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         osc_en_r <= 1'b1;
         mode_r <= pmc_mode_t'(PMC_RUN);
      end else begin
         osc_en_r <= (state_nxt != PMC_HALT); // see [R16] [R14]
         mode_r <= mode_code(state_nxt);
      end
   end

   assign OSC_ENABLE_O = osc_en_r;
   assign CORE_CLK_EN_O = core_en_r;
   assign PERIPH_CLK_EN_O = per_en_r;
   assign TIMEBASE_CLK_EN_O = tb_en_r;
   assign MODE_O = mode_r;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   a_wait_mask_entry: assert property ((state_r == PMC_RUN) && WAIT_INSTR_I |=> // see [R06]
      (state_r == PMC_WAIT) && mask_force_r && MASK_VALUE_O == 2'b10)
      else $error("wait entry without mask force");
   a_wait_core_off: assert property ((state_r == PMC_WAIT) && // see [R05]
      $past(state_r) == PMC_WAIT |-> !core_en_r)
      else $error("core clock running in wait");
   a_wait_wakeup: assert property ((state_r == PMC_WAIT) && irq_s |=> // see [R07]
      (state_r == PMC_RUN) ##0 (irq_svc_r || rst_vec_r))
      else $error("wait not left on interrupt");
   a_halt_select: assert property ((state_r == PMC_RUN) && !WAIT_INSTR_I && // see [R08]
      HALT_INSTR_I |=> (state_r == (($past(osc_ie)) ? PMC_AHALT : PMC_HALT)))
      else $error("wrong halt mode chosen");
   a_ahalt_fast_exit: assert property ((state_r == PMC_AHALT) && !rstreq_s && // see [R09]
      tbase_s |=> (state_r == PMC_RUN) && irq_svc_r)
      else $error("active-halt exit not immediate");
   a_ahalt_no_wdg: assert property ((state_r == PMC_RUN) && HALT_INSTR_I && osc_ie // see [R12]
      |=> !wdg_rst_r)
      else $error("watchdog reset in active-halt");
   a_halt_osc_off: assert property ((state_r == PMC_HALT) |-> !osc_en_r && !per_en_r) // see [R16]
      else $error("oscillator running in halt");
   a_stab_length: assert property ($rose(state_r == PMC_STAB) |-> // see [R14]
      (state_r == PMC_STAB && !core_en_r)[*8])
      else $error("stabilisation delay cut short");
   a_stab_load: assert property ($rose(state_r == PMC_STAB) |-> // see [R13]
      stab_cnt_r == (($past(stab_long)) ? 13'd4095 : 13'd255))
      else $error("stabilisation count wrong");
   a_div_boundary: assert property (lim_r != $past(lim_r) |-> $past(tick)) // see [R19]
      else $error("divider changed mid period");

   c_slow_wait: cover property ((state_r == PMC_WAIT) && slow_en && per_en_r);
   c_ahalt_wake: cover property ((state_r == PMC_AHALT) ##1 (state_r == PMC_RUN));
   c_halt_stab: cover property ((state_r == PMC_STAB) && stab_cnt_r == 13'd0);
   c_wdg_reset: cover property (wdg_rst_r);
endmodule

`default_nettype wire

// ===== pmc_ctrl_assume_none.sv
// intentionally empty design unit kept out; see controller file
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== pmc_core_model.sv
// core-side model: issues wait and halt instruction strobes and counts
// the service and reset-vector hand-offs that the controller makes
// assumes it shares the master clock and reset with the controller
`timescale 1ns/1ns
`default_nettype none
module pmc_core_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic irq_service_i,
   input wire logic reset_vector_i,
   output var logic wait_instr_o,
   output var logic halt_instr_o,
   output var int svc_count_o,
   output var int vec_count_o
);
   ////////////////////////////////////////////////////////////////////
   // strobes last exactly one master cycle, as a decoded opcode would
   initial begin
      wait_instr_o = 1'b0;
      halt_instr_o = 1'b0;
   end
   task automatic issue(input logic halt);
      @(posedge clk_i);
      wait_instr_o <= !halt;
      halt_instr_o <= halt;
      @(posedge clk_i);
      wait_instr_o <= 1'b0;
      halt_instr_o <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////
   // each service pulse stands for a flag push and vector fetch
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         svc_count_o <= 0;
         vec_count_o <= 0;
      end else begin
         svc_count_o <= svc_count_o + int'(irq_service_i);
         vec_count_o <= vec_count_o + int'(reset_vector_i);
      end
   end
endmodule
`default_nettype wire

// ===== tb.sv
// testbench of the power mode controller: apb, mode entry and wake paths
// assumes the core model file is compiled first; one 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defines.svh"
module tb;
   import pmc_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, wait_s, halt_s;
   logic irq, hwake, tbirq, rreq, wdg, wopt, osc, core_en, per_en, tb_en;
   logic mforce, svc, rvec, wrst, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0] mval;
   pmc_mode_t mode;
   int svc_n, vec_n, err_total, samples_checked, cycles, n_core, n_per, n_wrst;
   pmc_ctrl u_dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .WAIT_INSTR_I(wait_s),
      .HALT_INSTR_I(halt_s), .IRQ_PENDING_I(irq), .HALT_WAKE_IRQ_I(hwake),
      .TIMEBASE_IRQ_I(tbirq), .RESET_REQ_I(rreq), .WDG_ACTIVE_I(wdg),
      .WDG_IN_HALT_OPT_I(wopt), .OSC_ENABLE_O(osc), .CORE_CLK_EN_O(core_en),
      .PERIPH_CLK_EN_O(per_en), .TIMEBASE_CLK_EN_O(tb_en), .MASK_FORCE_O(mforce),
      .MASK_VALUE_O(mval), .IRQ_SERVICE_O(svc), .RESET_VECTOR_O(rvec),
      .WDG_RESET_O(wrst), .MODE_O(mode));
   pmc_core_model u_core (.clk_i(clk), .rst_i(rst), .irq_service_i(svc),
      .reset_vector_i(rvec), .wait_instr_o(wait_s), .halt_instr_o(halt_s),
      .svc_count_o(svc_n), .vec_count_o(vec_n));
   ////////////////////////////////////////////////////////////////////
   // clock, and enable pulses tallied at the settled falling edge
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      n_core += int'(core_en);
      n_per += int'(per_en);
      n_wrst += int'(wrst);
   end
   // a hang is cut short well past the fewer than two thousand cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer; the request stands until pready is seen high at a
   // rising edge, and read data and error are taken at that same edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // counts core and peripheral enables over n cycles
   task automatic span(input int n, input int ec, input int ep);
      int c, p;
      c = n_core;
      p = n_per;
      repeat (n) @(negedge clk);
      chk("core_en", n_core - c, ec);
      chk("per_en", n_per - p, ep);
   endtask
   task automatic enter(input logic halt, input logic [2:0] m);
      u_core.issue(halt);
      @(negedge clk);
      chk("mforce", mforce, 1'b1);
      chk("mode", mode, m);
      chk("mval", mval, 2'b10);
      @(negedge clk);
      chk("mforce1", mforce, 1'b0);
   endtask
   // waits for run, counting stabilisation cycles, then checks the hand-off;
   // a delay already under way when called has its first cycle counted too
   task automatic wake(input int stab, input logic vec);
      int n, st, s, v;
      n = 0;
      st = (mode === 3'd4) ? 1 : 0;
      s = svc_n;
      v = vec_n;
      while (mode !== 3'd0 && n < 1000) begin
         @(negedge clk);
         n++;
         if (mode === 3'd4) st++;
      end
      chk("wake_cycles", n <= stab + 6, 1'b1);
      chk("stab", st, stab);
      repeat (3) @(negedge clk);
      chk("svc", svc_n - s, !vec);
      chk("vec", vec_n - v, vec);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("mode", mode, 3'd0);
      chk("osc", osc, 1'b1);
      span(16, 16, 16);
      apb(1'b0, `PMC_CTRL_OFS, 32'h0);
      chk("ctrl", q, 32'h0);
      apb(1'b1, `PMC_STAT_OFS, 32'h1f);
      apb(1'b0, `PMC_STAT_OFS, 32'h0);
      chk("stat", q, 32'h8);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped", {q[30:0], e}, 32'h1);
      $display("test reset done");
   endtask
   task automatic t_slow;
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, `PMC_CTRL_OFS, 32'(d * 2 + 1));
         repeat (40) @(negedge clk);
         span(64, 64 >> (d + 1), 64 >> (d + 1));
      end
      apb(1'b0, `PMC_STAT_OFS, 32'h0);
      chk("stat_slow", q, 32'h18);
      $display("test slow done");
   endtask
   task automatic t_wait;
      apb(1'b1, `PMC_CTRL_OFS, 32'h3);
      repeat (40) @(negedge clk);
      enter(1'b0, 3'd1);
      span(64, 0, 16);
      u_core.issue(1'b1);
      @(negedge clk);
      chk("mode_kept", mode, 3'd1);
      @(posedge clk);
      irq <= 1'b1;
      wake(0, 1'b0);
      @(posedge clk);
      irq <= 1'b0;
      $display("test wait done");
   endtask
   task automatic t_halt;
      int w0;
      for (int o = 0; o < 2; o++) begin
         apb(1'b1, `PMC_CTRL_OFS, 32'h0);
         wdg <= 1'b1;
         wopt <= o[0];
         w0 = n_wrst;
         enter(1'b1, 3'd3);
         span(8, 0, 0);
         chk("osc", {osc, tb_en}, 2'b00);
         chk("wdg_rst", n_wrst - w0, 1 - o);
         @(posedge clk);
         hwake <= 1'b1;
         wake(256, 1'b0);
         @(posedge clk);
         hwake <= 1'b0;
      end
      $display("test halt done");
   endtask
   task automatic t_ahalt;
      int w0;
      apb(1'b1, `PMC_CTRL_OFS, 32'h8);
      w0 = n_wrst;
      enter(1'b1, 3'd2);
      span(8, 0, 0);
      chk("osc_tb", {osc, tb_en}, 2'b11);
      chk("wdg_rst", n_wrst - w0, 0);
      @(posedge clk);
      tbirq <= 1'b1;
      wake(0, 1'b0);
      @(posedge clk);
      tbirq <= 1'b0;
      enter(1'b1, 3'd2);
      @(posedge clk);
      rreq <= 1'b1;
      wake(256, 1'b1);
      @(posedge clk);
      rreq <= 1'b0;
      $display("test active-halt done");
   endtask
   // a wake interrupt already pending must not let the device stay down
   task automatic t_pending;
      @(posedge clk);
      hwake <= 1'b1;
      repeat (4) @(negedge clk);
      enter(1'b1, 3'd2);
      wake(0, 1'b0);
      apb(1'b1, `PMC_CTRL_OFS, 32'h0);
      enter(1'b1, 3'd3);
      wake(256, 1'b0);
      @(posedge clk);
      hwake <= 1'b0;
      $display("test pending done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      {rst, psel, penable, pwrite, irq, hwake, tbirq, rreq, wdg, wopt} = 10'h200;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      t_reset;
      t_slow;
      t_wait;
      t_halt;
      t_ahalt;
      t_pending;
      finish_test;
   end
endmodule
`default_nettype wire
